/* shared/cal_gpio_pkg.sv */
// Constants shared by the calibration and pin register bank
package cal_gpio_pkg;
  // Register addresses
  localparam logic [6:0] ADDR_RESERVED_0A     = 7'h0A;
  localparam logic [6:0] ADDR_OFFSET_LOW      = 7'h0B;
  localparam logic [6:0] ADDR_OFFSET_HIGH     = 7'h0C;
  localparam logic [6:0] ADDR_RESERVED_0D     = 7'h0D;
  localparam logic [6:0] ADDR_GAIN_LOW        = 7'h0E;
  localparam logic [6:0] ADDR_GAIN_HIGH       = 7'h0F;
  localparam logic [6:0] ADDR_PIN_STATE       = 7'h10;
  localparam logic [6:0] ADDR_PIN_FUNCTION    = 7'h11;
  // Values after reset
  localparam logic [7:0] RST_RESERVED         = 8'h00;
  localparam logic [7:0] RST_OFFSET_LOW       = 8'h00;
  localparam logic [7:0] RST_OFFSET_HIGH      = 8'h00;
  localparam logic [7:0] RST_GAIN_LOW         = 8'h00;
  localparam logic [7:0] RST_GAIN_HIGH        = 8'h40;
  localparam logic [3:0] RST_PIN_DIR          = 4'h0;
  localparam logic [3:0] RST_PIN_LEVEL        = 4'h0;
  localparam logic [3:0] RST_PIN_FUNCTION     = 4'h0;
  // Field positions
  localparam int         PIN_DIR_LSB          = 4;
  localparam int         PIN_LEVEL_LSB        = 0;
  // Serial frame: command byte then data byte
  localparam int         CMD_BITS             = 8;
  localparam int         FRAME_BITS           = 16;
  localparam int         READ_FLAG_BIT        = 7;
endpackage : cal_gpio_pkg

/* shared/reg_access_if.sv */
// Register access carrier between serial port and register bank
`timescale 1ns/100ps
interface reg_access_if;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic [7:0] rdata;
  modport port (output addr, output wdata, output wr_stb, input rdata);
  modport regs (input addr, input wdata, input wr_stb, output rdata);
endinterface : reg_access_if

/* src/spi_reg_port.sv */
// Mode 1 serial slave that turns frames into register reads and writes
`timescale 1ns/100ps
module spi_reg_port
  import cal_gpio_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Serial pins
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic mosi_in,
  output logic      miso_out,
  output logic      miso_oe_out,
  // Register side
  reg_access_if.port bus
);
  import cal_gpio_pkg::*;

  logic       sclk_d,  next_sclk_d;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift,   next_shift;
  logic [7:0] cmd,     next_cmd;
  logic [7:0] tx,      next_tx;
  logic [7:0] wdata,   next_wdata;
  logic       load,    next_load;
  logic       miso,    next_miso;
  logic       wr_stb,  next_wr_stb;
  logic       rise;
  logic       fall;

  assign rise = sclk_in & ~sclk_d;
  assign fall = ~sclk_in & sclk_d;

  // Frame decode: sample on falling edges, launch on rising edges
  always_comb
  begin
    next_sclk_d  = sclk_in;
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    next_cmd     = cmd;
    next_tx      = tx;
    next_wdata   = wdata;
    next_load    = 1'b0;
    next_miso    = miso;
    next_wr_stb  = 1'b0;
    if (cs_n_in)
    begin
      next_bit_cnt = 5'h00;
      next_miso    = 1'b0;
    end
    else
    begin
      if (fall && bit_cnt < 5'(FRAME_BITS))
      begin
        next_shift   = {shift[6:0], mosi_in};
        next_bit_cnt = bit_cnt + 5'h01;
        if (bit_cnt == 5'(CMD_BITS - 1))
        begin
          next_cmd  = {shift[6:0], mosi_in};
          next_load = 1'b1;
        end
        if (bit_cnt == 5'(FRAME_BITS - 1) && !cmd[READ_FLAG_BIT])
        begin
          next_wdata  = {shift[6:0], mosi_in};
          next_wr_stb = 1'b1;
        end
      end
      // Read data is fetched one cycle after the command lands
      if (load)
        next_tx = bus.rdata;
      if (rise && bit_cnt >= 5'(CMD_BITS))
      begin
        next_miso = tx[7];
        next_tx   = {tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sclk_d  <= 1'b0;
      bit_cnt <= 5'h00;
      shift   <= 8'h00;
      cmd     <= 8'h00;
      tx      <= 8'h00;
      wdata   <= 8'h00;
      load    <= 1'b0;
      miso    <= 1'b0;
      wr_stb  <= 1'b0;
    end
    else
    begin
      sclk_d  <= next_sclk_d;
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
      cmd     <= next_cmd;
      tx      <= next_tx;
      wdata   <= next_wdata;
      load    <= next_load;
      miso    <= next_miso;
      wr_stb  <= next_wr_stb;
    end
  end

  assign bus.addr    = cmd[6:0];
  assign bus.wdata   = wdata;
  assign bus.wr_stb  = wr_stb;
  assign miso_out    = miso;
  assign miso_oe_out = ~cs_n_in;

  // While selected, output bit only moves after a rising serial clock edge
  property p_miso_on_rise;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!cs_n_in && !$past(cs_n_in) && !rise) |=> $stable(miso_out);
  endproperty
  a_miso_on_rise: assert property (p_miso_on_rise)
    else $error("data output changed without a rising serial clock");
endmodule : spi_reg_port

/* src/calibration_and_gpio_regs.sv */
// Calibration words and four-pin general-purpose register bank
// Operation
// - Register 0Ah is read-only and reads zero; host writes only zero.
// - Register 0Dh is read-only and reads zero; host writes only zero.
// - Offset word: low byte 0Bh, high byte 0Ch, both reset to zero.
// - Gain word: low byte 0Eh resets zero, high byte 0Fh resets 40h.
// - Pin state bits 7:4 set direction: 0 output (reset), 1 input.
// - Pin state bits 3:0 drive output pins, report sampled input pins.
// - Pin function bits 3:0: 0 analog (reset), 1 digital pin.
// - Pin function register at 11h; upper four bits read zero.
// - Six-input variant: pins start disabled until function bits set.
// - Serial access in mode 1: idle low, launch rising, sample falling.
`timescale 1ns/100ps
module calibration_and_gpio_regs
  import cal_gpio_pkg::*;
#(
  parameter int PIN_COUNT = 4
)
(
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Serial register port
  input  wire logic                 sclk_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 mosi_in,
  output logic                      miso_out,
  output logic                      miso_oe_out,
  // General-purpose pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe_out,
  // Calibration words toward the conversion path
  output logic [15:0]               offset_correction_word_out,
  output logic [15:0]               gain_correction_word_out
);
  import cal_gpio_pkg::*;

  reg_access_if bus ();

  spi_reg_port u_port (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .sclk_in     (sclk_in),
    .cs_n_in     (cs_n_in),
    .mosi_in     (mosi_in),
    .miso_out    (miso_out),
    .miso_oe_out (miso_oe_out),
    .bus         (bus.port)
  );

  // Address match, shared by the write decode and the read mux
  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction : hit

  logic [7:0]           offset_corr_low,  next_offset_corr_low;
  logic [7:0]           offset_corr_high, next_offset_corr_high;
  logic [7:0]           gain_corr_low,    next_gain_corr_low;
  logic [7:0]           gain_corr_high,   next_gain_corr_high;
  logic [PIN_COUNT-1:0] pin_dir,          next_pin_dir;
  logic [PIN_COUNT-1:0] pin_level,        next_pin_level;
  logic [PIN_COUNT-1:0] pin_function,     next_pin_function;
  logic [PIN_COUNT-1:0] pin_oe,           next_pin_oe;
  logic [PIN_COUNT-1:0] level_view;

  // Register writes; read-only bytes simply ignore the strobe
  always_comb
  begin
    next_offset_corr_low  = offset_corr_low;
    next_offset_corr_high = offset_corr_high;
    next_gain_corr_low    = gain_corr_low;
    next_gain_corr_high   = gain_corr_high;
    next_pin_dir          = pin_dir;
    next_pin_level        = pin_level;
    next_pin_function     = pin_function;
    if (bus.wr_stb)
    begin
      if (hit(bus.addr, ADDR_OFFSET_LOW))
        next_offset_corr_low = bus.wdata;
      if (hit(bus.addr, ADDR_OFFSET_HIGH))
        next_offset_corr_high = bus.wdata;
      if (hit(bus.addr, ADDR_GAIN_LOW))
        next_gain_corr_low = bus.wdata;
      if (hit(bus.addr, ADDR_GAIN_HIGH))
        next_gain_corr_high = bus.wdata;
      if (hit(bus.addr, ADDR_PIN_STATE))
      begin
        next_pin_dir   = bus.wdata[PIN_DIR_LSB +: PIN_COUNT];
        next_pin_level = bus.wdata[PIN_LEVEL_LSB +: PIN_COUNT];
      end
      // Upper bits are dropped, so they always read back as zero
      if (hit(bus.addr, ADDR_PIN_FUNCTION))
        next_pin_function = bus.wdata[PIN_COUNT-1:0];
    end
    // Driver only on digital pins set as outputs
    next_pin_oe = next_pin_function & ~next_pin_dir;
  end

  // All control resets to analog use, so every pin starts disabled
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      offset_corr_low  <= RST_OFFSET_LOW;
      offset_corr_high <= RST_OFFSET_HIGH;
      gain_corr_low    <= RST_GAIN_LOW;
      gain_corr_high   <= RST_GAIN_HIGH;
      pin_dir          <= RST_PIN_DIR;
      pin_level        <= RST_PIN_LEVEL;
      pin_function     <= RST_PIN_FUNCTION;
      pin_oe           <= '0;
    end
    else
    begin
      offset_corr_low  <= next_offset_corr_low;
      offset_corr_high <= next_offset_corr_high;
      gain_corr_low    <= next_gain_corr_low;
      gain_corr_high   <= next_gain_corr_high;
      pin_dir          <= next_pin_dir;
      pin_level        <= next_pin_level;
      pin_function     <= next_pin_function;
      pin_oe           <= next_pin_oe;
    end
  end

  // Input pins report the pin, output pins report the latch
  assign level_view = (pin_dir & pin_in) | (~pin_dir & pin_level);

  // Read mux; unmapped and reserved addresses read zero
  always_comb
  begin
    bus.rdata = RST_RESERVED;
    if (hit(bus.addr, ADDR_OFFSET_LOW))
      bus.rdata = offset_corr_low;
    if (hit(bus.addr, ADDR_OFFSET_HIGH))
      bus.rdata = offset_corr_high;
    if (hit(bus.addr, ADDR_GAIN_LOW))
      bus.rdata = gain_corr_low;
    if (hit(bus.addr, ADDR_GAIN_HIGH))
      bus.rdata = gain_corr_high;
    if (hit(bus.addr, ADDR_PIN_STATE))
      bus.rdata = {pin_dir, level_view};
    if (hit(bus.addr, ADDR_PIN_FUNCTION))
      bus.rdata = {4'h0, pin_function};
  end

  assign pin_out                    = pin_level;
  assign pin_oe_out                 = pin_oe;
  assign offset_correction_word_out = {offset_corr_high, offset_corr_low};
  assign gain_correction_word_out   = {gain_corr_high, gain_corr_low};

  sequence s_write(logic [6:0] a);
    bus.wr_stb && bus.addr == a;
  endsequence

  property p_res0a_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
      bus.addr == ADDR_RESERVED_0A |-> bus.rdata == 8'h00;
  endproperty
  a_res0a_zero: assert property (p_res0a_zero)
    else $error("reserved register 0Ah read nonzero");

  property p_res0d_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
      bus.addr == ADDR_RESERVED_0D |-> bus.rdata == 8'h00;
  endproperty
  a_res0d_zero: assert property (p_res0d_zero)
    else $error("reserved register 0Dh read nonzero");

  property p_offset_high_write;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_write(ADDR_OFFSET_HIGH) |=>
        offset_correction_word_out[15:8] == $past(bus.wdata);
  endproperty
  a_offset_high_write: assert property (p_offset_high_write)
    else $error("offset high byte not updated by write");

  property p_gain_reset;
    @(posedge clk_in)
      !rst_n_in |=> gain_correction_word_out == 16'h4000;
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("gain word wrong after reset");

  property p_input_no_drive;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_write(ADDR_PIN_STATE) ##1 1'b1 |=> (pin_oe_out & $past(pin_dir)) == '0;
  endproperty
  a_input_no_drive: assert property (p_input_no_drive)
    else $error("input pin is driven");

  property p_level_view;
    @(posedge clk_in) disable iff (!rst_n_in)
      hit(bus.addr, ADDR_PIN_STATE) |->
        bus.rdata[3:0] == ((pin_dir & pin_in) | (~pin_dir & pin_out));
  endproperty
  a_level_view: assert property (p_level_view)
    else $error("pin level readback wrong");

  property p_function_write;
    @(posedge clk_in) disable iff (!rst_n_in)
      s_write(ADDR_PIN_FUNCTION) ##1 1'b1 |=>
        pin_oe_out == ($past(bus.wdata[3:0], 2) & ~$past(pin_dir));
  endproperty
  a_function_write: assert property (p_function_write)
    else $error("pin function write not reflected in drivers");

  property p_func_upper_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
      bus.addr == ADDR_PIN_FUNCTION |-> bus.rdata[7:4] == 4'h0;
  endproperty
  a_func_upper_zero: assert property (p_func_upper_zero)
    else $error("pin function upper bits nonzero");

  property p_reset_disabled;
    @(posedge clk_in)
      !rst_n_in |=> pin_oe_out == '0;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled)
    else $error("pins not disabled after reset");

  property p_analog_no_drive;
    @(posedge clk_in) disable iff (!rst_n_in)
      (pin_oe_out & ~pin_function) == '0;
  endproperty
  a_analog_no_drive: assert property (p_analog_no_drive)
    else $error("analog pin driven");
endmodule : calibration_and_gpio_regs

/* tb/spi_host_model.sv */
// Host side of the mode 1 serial register port
`timescale 1ns/100ps
module spi_host_model
(
  // Clock
  input  wire logic clk_in,
  // Serial pins
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  // Idle: serial clock low and still, device deselected
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // One frame; fewer than 16 bits gives an aborted frame
  task automatic xfer(input logic [15:0] frame, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (2) @(negedge clk_in);
    for (int i = 0; i < nbits; i++)
    begin
      sclk_out = 1'b1;
      mosi_out = frame[15-i];
      repeat (4) @(negedge clk_in);
      if (i >= 8)
      begin
        rd = {rd[6:0], miso_in};
      end
      sclk_out = 1'b0;
      repeat (4) @(negedge clk_in);
    end
    cs_n_out = 1'b1;
    // Released data line must not keep its last value
    mosi_out = ~mosi_out;
    repeat (6) @(negedge clk_in);
  endtask : xfer
endmodule : spi_host_model

/* tb/calibration_and_gpio_regs_tb.sv */
// Self-checking bench for the calibration and pin register bank
`timescale 1ns/100ps
module calibration_and_gpio_regs_tb;
  import cal_gpio_pkg::*;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic [3:0]  pin_in   = 4'h0;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [15:0] offset_word;
  logic [15:0] gain_word;
  logic [7:0]  mdl [ADDR_RESERVED_0A:ADDR_PIN_FUNCTION];
  logic [31:0] seed       = 32'h1BC65904;
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  logic        oe_gap     = 1'b0;

  calibration_and_gpio_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_out(pin_oe), .offset_correction_word_out(offset_word),
    .gain_correction_word_out(gain_word));
  spi_host_model host_u (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi));

  // Clock and hang guard; a full run needs about 33000 cycles
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      error_cnt++;
      summarize();
    end
  end

  // Output enable must stand for the whole time the device is selected
  always @(posedge clk_in)
  begin
    if (!cs_n && miso_oe !== 1'b1) oe_gap <= 1'b1;
  end

  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Read view: input pins report the sampled level, output pins the stored one
  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    logic [3:0] dir;
    dir = mdl[ADDR_PIN_STATE][7:4];
    if (a == ADDR_PIN_STATE) return {dir, (dir & pin_in) | (~dir & mdl[a][3:0])};
    if (a == ADDR_PIN_FUNCTION) return {4'h0, mdl[a][3:0]};
    if (a >= ADDR_OFFSET_LOW && a <= ADDR_GAIN_HIGH && a != ADDR_RESERVED_0D) return mdl[a];
    return 8'h00;
  endfunction : exp_rd

  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[ADDR_GAIN_HIGH] = 8'h40;
  endtask : do_reset

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    host_u.xfer({1'b0, a, d}, 16, v);
    if (a inside {ADDR_OFFSET_LOW, ADDR_OFFSET_HIGH, ADDR_GAIN_LOW, ADDR_GAIN_HIGH,
        ADDR_PIN_STATE}) mdl[a] = d;
    if (a == ADDR_PIN_FUNCTION) mdl[a] = {4'h0, d[3:0]};
  endtask : wr

  task automatic rd(input logic [6:0] a);
    logic [7:0] v;
    pin_in = 4'(xorshift());
    host_u.xfer({1'b1, a, 8'h00}, 16, v);
    chk("read data", {8'h00, exp_rd(a)}, {8'h00, v});
  endtask : rd

  // Every register, one unmapped place, and the outputs fed by them
  task automatic chk_regs();
    for (logic [6:0] a = ADDR_RESERVED_0A; a <= ADDR_PIN_FUNCTION; a++) rd(a);
    rd(7'h20);
    chk("offset", {mdl[ADDR_OFFSET_HIGH], mdl[ADDR_OFFSET_LOW]}, offset_word);
    chk("gain", {mdl[ADDR_GAIN_HIGH], mdl[ADDR_GAIN_LOW]}, gain_word);
    chk("pin_out", {12'h000, mdl[ADDR_PIN_STATE][3:0]}, {12'h000, pin_out});
    chk("pin_oe", {12'h000, mdl[ADDR_PIN_FUNCTION][3:0] & ~mdl[ADDR_PIN_STATE][7:4]},
        {12'h000, pin_oe});
    chk("miso idle", 16'h0000, {14'h0000, miso_oe, miso});
    chk("miso_oe in frame", 16'h0000, {15'h0000, oe_gap});
  endtask : chk_regs

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Reset values, random traffic with reserved and aborted frames, reset again
  initial
  begin
    logic [7:0] d;
    logic [7:0] v;
    do_reset();
    chk_regs();
    for (int r = 0; r < 12; r++)
    begin
      for (logic [6:0] a = ADDR_RESERVED_0A; a <= ADDR_PIN_FUNCTION; a++)
      begin
        d = 8'(xorshift());
        if (a == ADDR_RESERVED_0A || a == ADDR_RESERVED_0D) d = 8'h00;
        if (a == ADDR_PIN_FUNCTION) d[7:4] = 4'h0;
        wr(a, d);
      end
      wr(7'h20, 8'(xorshift()));
      host_u.xfer({1'b0, ADDR_OFFSET_LOW, 8'(xorshift())}, 10, v);
      chk_regs();
    end
    do_reset();
    chk_regs();
    summarize();
  end
endmodule : calibration_and_gpio_regs_tb
